// ==== phy_ident_and_advert_regs.v ====
// identifier and advertisement registers behind a serial management slave
`timescale 1ns/1ps
`include "phy_mgmt_map.vh"
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module phy_ident_and_advert_regs
#(
  parameter        ZERO_IDENT   = 0,           // 1 returns an all-zero identifier
  parameter [21:0] ORG_IDENT    = 22'h2A5A5A,  // org identifier bits 3..24, arbitrary value
  parameter [5:0]  MODEL_NUMBER = 6'h15,       // model number, arbitrary value
  parameter [3:0]  MODEL_REV    = 4'h3         // model revision, arbitrary value
)
(
  input  wire        core_clk,       // 250 MHz core clock
  input  wire        rst_n,          // synchronous reset, active low
  input  wire        mdc,            // management clock pin
  input  wire        mdio_in,        // management data pin, input side
  output reg         mdio_out,       // management data pin, output side
  output reg         mdio_oe,        // high while the block drives management data
  input  wire [4:0]  phy_addr,       // management address straps
  input  wire [3:0]  ability_strap,  // straps: 100 full, 100, 10 full, 10
  output reg  [15:0] advert_word     // abilities offered to the link partner
);

  //////////////////////////////////////////////////////////////////////////////
  // frame states
  localparam [5:0] ST_IDLE  = 6'h01;
  localparam [5:0] ST_START = 6'h02;
  localparam [5:0] ST_OP    = 6'h04;
  localparam [5:0] ST_ADDR  = 6'h08;
  localparam [5:0] ST_TA    = 6'h10;
  localparam [5:0] ST_DATA  = 6'h20;

  //////////////////////////////////////////////////////////////////////////////
  // fixed identifier words
  wire [15:0] ident_high_val;
  wire [15:0] ident_low_val;

  assign ident_high_val = (ZERO_IDENT != 0) ? 16'h0000 : ORG_IDENT[21:6];
  assign ident_low_val  = (ZERO_IDENT != 0) ? 16'h0000 :
                          {ORG_IDENT[5:0], MODEL_NUMBER, MODEL_REV};

  //////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  wire [10:0] pins_s;
  wire        mdc_s;
  wire        mdio_s;
  wire [3:0]  strap_s;
  wire [4:0]  phy_addr_s;

  sync_two_ff
  #(
    .WIDTH (11)
  )
  u_pin_sync
  (
    .core_clk (core_clk),
    .async_in ({mdc, mdio_in, ability_strap, phy_addr}),
    .sync_out (pins_s)
  );

  assign mdc_s      = pins_s[10];
  assign mdio_s     = pins_s[9];
  assign strap_s    = pins_s[8:5];
  assign phy_addr_s = pins_s[4:0];

  //////////////////////////////////////////////////////////////////////////////
  // state
  reg        mdc_prev_ff;
  reg [5:0]  state_ff;
  reg [5:0]  pre_cnt_ff;
  reg [3:0]  bit_cnt_ff;
  reg [15:0] shift_ff;
  reg [15:0] rd_shift_ff;
  reg [4:0]  reg_addr_ff;
  reg        is_read_ff;
  reg        selected_ff;
  reg        strap_done_ff;

  reg [5:0]  nxt_state;
  reg [5:0]  nxt_pre_cnt;
  reg [3:0]  nxt_bit_cnt;
  reg [15:0] nxt_shift;
  reg [15:0] nxt_rd_shift;
  reg [4:0]  nxt_reg_addr;
  reg        nxt_is_read;
  reg        nxt_selected;
  reg        nxt_strap_done;
  reg        nxt_mdio_out;
  reg        nxt_mdio_oe;
  reg [15:0] nxt_advert;

  wire       mdc_rise;
  wire [1:0] op_code;
  wire [9:0] addr_word;
  wire [15:0] wr_word;

  assign mdc_rise  = mdc_s & ~mdc_prev_ff;
  assign op_code   = {shift_ff[0], mdio_s};
  assign addr_word = {shift_ff[8:0], mdio_s};
  assign wr_word   = {shift_ff[14:0], mdio_s};

  //////////////////////////////////////////////////////////////////////////////
  // read data selection; unmapped addresses read as zero
  function [15:0] read_value;
    input [4:0]  addr;
    input [15:0] id_high;
    input [15:0] id_low;
    input [15:0] advert;
    begin
      case (addr)
        `REG_IDENT_HIGH: read_value = id_high;
        `REG_IDENT_LOW:  read_value = id_low;
        `REG_NEG_ADVERT: read_value = advert;
        default:         read_value = 16'h0000;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // frame decoder and register update
  // preamble suppression is not offered: every frame needs 32 ones first
  always @*
  begin
    nxt_state      = state_ff;
    nxt_pre_cnt    = pre_cnt_ff;
    nxt_bit_cnt    = bit_cnt_ff;
    nxt_shift      = shift_ff;
    nxt_rd_shift   = rd_shift_ff;
    nxt_reg_addr   = reg_addr_ff;
    nxt_is_read    = is_read_ff;
    nxt_selected   = selected_ff;
    nxt_strap_done = 1'b1;
    nxt_mdio_out   = mdio_out;
    nxt_mdio_oe    = mdio_oe;
    nxt_advert     = advert_word;

    // straps are taken on the first edge after release, once the sync chain has settled
    if (!strap_done_ff)
    begin
      nxt_advert[`ADV_STRAP_MSB:`ADV_STRAP_LSB] = strap_s;
    end

    if (mdc_rise)
    begin
      case (state_ff)
        ST_IDLE:
        begin
          if (mdio_s)
          begin
            if (pre_cnt_ff != `MGMT_PREAMBLE_BITS)
            begin
              nxt_pre_cnt = pre_cnt_ff + 6'h01;
            end
          end
          else if (pre_cnt_ff == `MGMT_PREAMBLE_BITS)
          begin
            nxt_state   = ST_START;
            nxt_pre_cnt = 6'h00;
          end
          else
          begin
            nxt_pre_cnt = 6'h00;
          end
        end
        ST_START:
        begin
          nxt_bit_cnt = 4'h0;
          nxt_state   = mdio_s ? ST_OP : ST_IDLE;
        end
        ST_OP:
        begin
          nxt_shift = {shift_ff[14:0], mdio_s};
          if (bit_cnt_ff == `MGMT_OP_LAST_BIT)
          begin
            nxt_bit_cnt = 4'h0;
            if (op_code == `MGMT_OP_READ)
            begin
              nxt_is_read = 1'b1;
              nxt_state   = ST_ADDR;
            end
            else if (op_code == `MGMT_OP_WRITE)
            begin
              nxt_is_read = 1'b0;
              nxt_state   = ST_ADDR;
            end
            else
            begin
              nxt_state = ST_IDLE;
            end
          end
          else
          begin
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end
        end
        ST_ADDR:
        begin
          nxt_shift = {shift_ff[14:0], mdio_s};
          if (bit_cnt_ff == `MGMT_ADDR_LAST_BIT)
          begin
            nxt_bit_cnt  = 4'h0;
            nxt_state    = ST_TA;
            nxt_selected = (addr_word[9:5] == phy_addr_s);
            nxt_reg_addr = addr_word[4:0];
            // snapshot taken here so the word cannot tear during shift-out
            nxt_rd_shift = read_value(addr_word[4:0], ident_high_val,
                                      ident_low_val, advert_word);
          end
          else
          begin
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end
        end
        ST_TA:
        begin
          if (bit_cnt_ff == 4'h0)
          begin
            nxt_bit_cnt = 4'h1;
            if (is_read_ff && selected_ff)
            begin
              nxt_mdio_oe  = 1'b1;
              nxt_mdio_out = 1'b0;
            end
          end
          else
          begin
            nxt_bit_cnt = 4'h0;
            nxt_state   = ST_DATA;
            if (is_read_ff && selected_ff)
            begin
              nxt_mdio_out = rd_shift_ff[15];
              nxt_rd_shift = {rd_shift_ff[14:0], 1'b0};
            end
          end
        end
        ST_DATA:
        begin
          nxt_shift = wr_word;
          if (bit_cnt_ff == `MGMT_DATA_LAST_BIT)
          begin
            nxt_bit_cnt  = 4'h0;
            nxt_state    = ST_IDLE;
            nxt_mdio_oe  = 1'b0;
            nxt_mdio_out = 1'b0;
            // identifier addresses are not decoded for writes, so they stay fixed
            if (!is_read_ff && selected_ff && (reg_addr_ff == `REG_NEG_ADVERT))
            begin
              // masked bits 14, 12, 9 always hold 0
              nxt_advert = wr_word & `ADV_WRITE_MASK;
            end
          end
          else
          begin
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
            if (is_read_ff && selected_ff)
            begin
              nxt_mdio_out = rd_shift_ff[15];
              nxt_rd_shift = {rd_shift_ff[14:0], 1'b0};
            end
          end
        end
        default:
        begin
          nxt_state   = ST_IDLE;
          nxt_pre_cnt = 6'h00;
          nxt_bit_cnt = 4'h0;
          nxt_mdio_oe = 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      mdc_prev_ff   <= 1'b0;
      state_ff      <= ST_IDLE;
      pre_cnt_ff    <= 6'h00;
      bit_cnt_ff    <= 4'h0;
      shift_ff      <= 16'h0000;
      rd_shift_ff   <= 16'h0000;
      reg_addr_ff   <= 5'h00;
      is_read_ff    <= 1'b0;
      selected_ff   <= 1'b0;
      strap_done_ff <= 1'b0;
      mdio_out      <= 1'b0;
      mdio_oe       <= 1'b0;
      advert_word   <= `ADV_RESET_VALUE;
    end
    else
    begin
      mdc_prev_ff   <= mdc_s;
      state_ff      <= nxt_state;
      pre_cnt_ff    <= nxt_pre_cnt;
      bit_cnt_ff    <= nxt_bit_cnt;
      shift_ff      <= nxt_shift;
      rd_shift_ff   <= nxt_rd_shift;
      reg_addr_ff   <= nxt_reg_addr;
      is_read_ff    <= nxt_is_read;
      selected_ff   <= nxt_selected;
      strap_done_ff <= nxt_strap_done;
      mdio_out      <= nxt_mdio_out;
      mdio_oe       <= nxt_mdio_oe;
      advert_word   <= nxt_advert;
    end
  end

endmodule

// ==== phy_mgmt_map.vh ====
// register offsets, field positions, reset values and frame constants of the management bank
`ifndef PHY_MGMT_MAP_VH
`define PHY_MGMT_MAP_VH

// register addresses on the management interface
`define REG_IDENT_HIGH      5'h02
`define REG_IDENT_LOW       5'h03
`define REG_NEG_ADVERT      5'h04

// advertisement word field positions
`define ADV_NEXT_PAGE_BIT   15
`define ADV_RSVD_HI_BIT     14
`define ADV_REMOTE_FAULT    13
`define ADV_RSVD_LO_BIT     12
`define ADV_ASYM_PAUSE      11
`define ADV_SYM_PAUSE       10
`define ADV_FOUR_PAIR       9
`define ADV_STRAP_MSB       8
`define ADV_STRAP_LSB       5
`define ADV_SEL_MSB         4
`define ADV_SEL_LSB         0

// writable bits of the advertisement word; bits 14, 12 and 9 always read 0
`define ADV_WRITE_MASK      16'hADFF
// reset value before the strap abilities are merged in: selector 00001
`define ADV_RESET_VALUE     16'h0001

// identifier word field positions
`define ID_LOW_ORG_MSB      15
`define ID_LOW_ORG_LSB      10
`define ID_LOW_MODEL_MSB    9
`define ID_LOW_MODEL_LSB    4
`define ID_LOW_REV_MSB      3
`define ID_LOW_REV_LSB      0

// management frame constants
`define MGMT_PREAMBLE_BITS  6'h20
`define MGMT_OP_READ        2'h2
`define MGMT_OP_WRITE       2'h1
`define MGMT_OP_LAST_BIT    4'h1
`define MGMT_ADDR_LAST_BIT  4'h9
`define MGMT_DATA_LAST_BIT  4'hF

`endif

// ==== sync_two_ff.v ====
// two flip-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module sync_two_ff
#(
  parameter WIDTH = 1
)
(
  input  wire             core_clk,   // destination clock
  input  wire [WIDTH-1:0] async_in,   // level from outside the clock domain
  output reg  [WIDTH-1:0] sync_out    // synchronised level
);

  reg [WIDTH-1:0] meta_ff;

  // no reset: the chain runs during reset so the levels are settled at release
  always @(posedge core_clk)
  begin
    meta_ff  <= async_in;
    sync_out <= meta_ff;
  end

endmodule

// ==== phy_regs_props.sv ====
// port checker for the identifier and advertisement bank
`timescale 1ns/1ps
module phy_regs_props
(
  input wire        core_clk,      // clock
  input wire        rst_n,         // reset
  input wire        mdc,           // mgmt clock
  input wire        mdio_in,       // mgmt data in
  input wire        mdio_out,      // mgmt data out
  input wire        mdio_oe,       // drive enable
  input wire [4:0]  phy_addr,      // address straps
  input wire [3:0]  ability_strap, // ability straps
  input wire [15:0] advert_word    // advertised word
);
  default clocking cb @(posedge core_clk); endclocking
  property p_rst_adv; !rst_n |=> advert_word == 16'h0001; endproperty
  a_rst_adv: assert property (p_rst_adv) else $error("advert reset value");
  property p_strap; disable iff (!rst_n)
    $rose(rst_n) |-> ##3 advert_word == {7'h00, ability_strap, 5'h01}; endproperty
  a_strap: assert property (p_strap) else $error("strap load");
  // the word is unknown before the first reset edge, so these wait for reset to lift
  property p_rsvd14; disable iff (!rst_n) advert_word[14] == 1'b0; endproperty
  a_rsvd14: assert property (p_rsvd14) else $error("bit 14 set");
  property p_rsvd12; disable iff (!rst_n) advert_word[12] == 1'b0; endproperty
  a_rsvd12: assert property (p_rsvd12) else $error("bit 12 set");
  property p_four_pair; disable iff (!rst_n) advert_word[9] == 1'b0; endproperty
  a_four_pair: assert property (p_four_pair) else $error("bit 9 set");
  property p_rst_oe; !rst_n |=> !mdio_oe; endproperty
  a_rst_oe: assert property (p_rst_oe) else $error("drive in reset");
  property p_ta_zero; disable iff (!rst_n) $rose(mdio_oe) |-> mdio_out == 1'b0; endproperty
  a_ta_zero: assert property (p_ta_zero) else $error("turnaround not 0");
  property p_oe_hold; disable iff (!rst_n) $rose(mdio_oe) |=> mdio_oe [*8]; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("drive too short");
  property p_rd_quiet; disable iff (!rst_n) mdio_oe |=> $stable(advert_word); endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read changed advert");
endmodule
bind phy_ident_and_advert_regs phy_regs_props props_u (.core_clk(core_clk), .rst_n(rst_n),
  .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
  .phy_addr(phy_addr), .ability_strap(ability_strap), .advert_word(advert_word));

// ==== mgmt_station.sv ====
// management station model: frames on a pulled-up data line
`timescale 1ns/1ps
module mgmt_station
#(
  parameter HALF = 8 // core cycles per mdc half period
)
(
  input  wire        core_clk,  // clock
  input  wire        mdio_out,  // block data
  input  wire        mdio_oe,   // block enable
  output reg         mdc,       // mgmt clock, low between frames
  output wire        mdio_line, // resolved line
  output reg         rd_stb,    // read word ready
  output reg  [15:0] rd_word    // read word
);
  reg host_en;
  reg host_bit;
  // pull-up: a released line reads 1
  assign mdio_line = mdio_oe ? mdio_out : (host_en ? host_bit : 1'b1);
  initial
  begin
    mdc = 1'b0;
    host_en = 1'b0;
    host_bit = 1'b1;
    rd_stb = 1'b0;
    rd_word = 16'h0000;
  end
  task frame(input [1:0] op, input [4:0] pa, input [4:0] ra, input [15:0] wd);
    reg [63:0] bits;
    integer    i;
    begin
      bits = {32'hFFFFFFFF, 2'b01, op, pa, ra, 2'b10, wd};
      for (i = 63; i >= 0; i = i - 1)
      begin
        host_en = !(op == 2'h2 && i < 18);
        host_bit = bits[i];
        repeat (HALF) @(negedge core_clk);
        mdc = 1'b1;
        if (i < 16)
          rd_word[i] = mdio_line;
        repeat (HALF) @(negedge core_clk);
        mdc = 1'b0;
      end
      host_en = 1'b0;
      repeat (2 * HALF) @(negedge core_clk);
      if (op == 2'h2)
      begin
        rd_stb = 1'b1;
        @(negedge core_clk);
        rd_stb = 1'b0;
      end
    end
  endtask
endmodule

// ==== phy_ident_and_advert_regs_bench.sv ====
// self-checking bench for the identifier and advertisement bank
`timescale 1ns/1ps
module phy_ident_and_advert_regs_bench;
  localparam [21:0] ORG   = 22'h1C3A5B; // arbitrary value
  localparam [5:0]  MODEL = 6'h2D;      // arbitrary value
  localparam [3:0]  REV   = 4'h9;       // arbitrary value
  reg         core_clk;
  reg         rst_n;
  reg  [4:0]  phy_addr;
  reg  [3:0]  ability_strap;
  reg         adv_stb;
  wire        mdc;
  wire        mdio_line;
  wire        mdio_out;
  wire        mdio_oe;
  wire        rd_stb;
  wire [15:0] rd_word;
  wire [15:0] advert_word;
  wire        mdio_out_z;
  wire        mdio_oe_z;
  wire        bus_out;
  wire        bus_oe;
  reg  [31:0] rnd;
  reg  [15:0] exp_q[$];
  reg  [15:0] adv_exp;
  reg  [15:0] d;
  integer     seed;
  integer     fails;
  integer     samples_checked;
  integer     cycles;
  integer     k;
  phy_ident_and_advert_regs #(.ORG_IDENT(ORG), .MODEL_NUMBER(MODEL), .MODEL_REV(REV)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio_line), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .phy_addr(phy_addr), .ability_strap(ability_strap),
    .advert_word(advert_word));
  // second bank answers at address xor 2 with the all-zero identifier option
  phy_ident_and_advert_regs #(.ZERO_IDENT(1)) zero_u (
    .core_clk(core_clk), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio_line), .mdio_out(mdio_out_z),
    .mdio_oe(mdio_oe_z), .phy_addr(phy_addr ^ 5'h02), .ability_strap(ability_strap),
    .advert_word());
  assign bus_oe  = mdio_oe | mdio_oe_z;
  assign bus_out = mdio_oe ? mdio_out : mdio_out_z;
  mgmt_station #(.HALF(8)) mst_u (.core_clk(core_clk), .mdio_out(bus_out), .mdio_oe(bus_oe),
    .mdc(mdc), .mdio_line(mdio_line), .rd_stb(rd_stb), .rd_word(rd_word));
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task complete_run;
    begin
      // a note never answered means a result went missing
      if (exp_q.size() != 0)
        fails = fails + 1;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task check_read(input [15:0] got);
    reg [15:0] exp;
    begin
      exp = exp_q.pop_front();
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
        fails = fails + 1;
        $display("mismatch at %0t: read got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task check_advert(input [15:0] got);
    reg [15:0] exp;
    begin
      exp = exp_q.pop_front();
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
        fails = fails + 1;
        $display("mismatch at %0t: advert got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // results are compared in arrival order against the oldest note
  always @(posedge core_clk)
  begin
    cycles = cycles + 1;
    if (rd_stb === 1'b1)
      check_read(rd_word);
    if (adv_stb === 1'b1)
      check_advert(advert_word);
    if (cycles == 60000)
    begin
      fails = fails + 1;
      complete_run;
    end
  end
  task rd(input [4:0] pa, input [4:0] ra, input [15:0] exp);
    begin
      exp_q.push_back(exp);
      mst_u.frame(2'h2, pa, ra, 16'h0000);
    end
  endtask
  task wr(input [4:0] pa, input [4:0] ra, input [15:0] wd);
    mst_u.frame(2'h1, pa, ra, wd);
  endtask
  task port(input [15:0] exp);
    begin
      exp_q.push_back(exp);
      adv_stb = 1'b1;
      @(negedge core_clk);
      adv_stb = 1'b0;
    end
  endtask
  initial
  begin
    seed = 17462;
    fails = 0;
    samples_checked = 0;
    cycles = 0;
    adv_stb = 1'b0;
    rst_n = 1'b0;
    rnd = $random(seed);
    phy_addr = rnd[4:0];
    ability_strap = rnd[8:5];
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge core_clk);
    adv_exp = {7'h00, ability_strap, 5'h01};
    port(adv_exp);
    rd(phy_addr, 5'h02, ORG[21:6]);
    rd(phy_addr, 5'h03, {ORG[5:0], MODEL, REV});
    rd(phy_addr, 5'h04, adv_exp);
    rd(phy_addr ^ 5'h02, 5'h02, 16'h0000);
    rd(phy_addr ^ 5'h02, 5'h03, 16'h0000);
    rd(phy_addr ^ 5'h02, 5'h04, adv_exp);
    for (k = 2; k < 4; k = k + 1)
    begin
      rnd = $random(seed);
      wr(phy_addr, k[4:0], rnd[15:0]);
    end
    rd(phy_addr, 5'h02, ORG[21:6]);
    rd(phy_addr, 5'h03, {ORG[5:0], MODEL, REV});
    for (k = 0; k < 4; k = k + 1)
    begin
      rnd = $random(seed);
      d = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h0000 : rnd[15:0];
      d = d & 16'hEFFF;
      wr(phy_addr, 5'h04, d);
      adv_exp = d & 16'hADFF;
      port(adv_exp);
      rd(phy_addr, 5'h04, adv_exp);
    end
    // another station address: no write, line left to the pull-up
    wr(phy_addr ^ 5'h01, 5'h04, 16'h0000);
    port(adv_exp);
    rd(phy_addr ^ 5'h01, 5'h04, 16'hFFFF);
    wr(phy_addr, 5'h07, 16'h0000);
    port(adv_exp);
    rd(phy_addr, 5'h07, 16'h0000);
    rnd = $random(seed);
    ability_strap = rnd[3:0];
    repeat (4) @(negedge core_clk);
    rst_n = 1'b0;
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge core_clk);
    adv_exp = {7'h00, ability_strap, 5'h01};
    port(adv_exp);
    rd(phy_addr, 5'h04, adv_exp);
    complete_run;
  end
endmodule
